// >>> rtl/scl_defs.svh
// Constants of the serial configuration loader
`ifndef SCL_DEFS_SVH
`define SCL_DEFS_SVH
`define SCL_READ_INSTR 8'h03
`define SCL_MARKER 8'haa
`define SCL_MARKER_ADDR 8'h00
`define SCL_DATA_ADDR 8'h01
`define SCL_LAST_ADDR 8'hff
`define SCL_LAST_WORD 6'h0f
`define SCL_LAST_LANE 2'h3
`define SCL_STRAP_WAIT 2'h3
`define SCL_CMD_BITS 5'h10
`define SCL_LAST_BIT 5'h17
`define SCL_FIRST_BIT 5'h00
`define SCL_ALL_LANES 4'hf
`endif

// >>> rtl/scl_pkg.sv
// Types of the serial configuration loader
package scl_pkg;
	typedef enum logic [2:0] {
		SCL_ST_STRAP = 3'b000,
		SCL_ST_SELECT = 3'b001,
		SCL_ST_SHIFT = 3'b010,
		SCL_ST_DESELECT = 3'b011,
		SCL_ST_DONE = 3'b100
	} scl_state_type;
endpackage

// >>> rtl/scl_loader.sv
// Start-up loader copying serial memory bytes into configuration space
`timescale 1ns/1ps
`include "scl_defs.svh"
module scl_loader (
	input wire logic clk,
	input wire logic reset,
	input wire logic serial_load_strap,
	input wire logic eeprom_clk,
	input wire logic eeprom_serial_in,
	output logic eeprom_chip_select_n,
	output logic eeprom_serial_out,
	output logic cfg_wr_en,
	output logic [7:0] cfg_wr_addr,
	output logic [31:0] cfg_wr_data,
	output logic loading,
	input wire logic acc_valid,
	input wire logic [3:0] acc_byte_en,
	input wire logic acc_single_mem,
	output logic acc_retry,
	output logic acc_accept,
	output logic acc_reject,
	output logic sys_int
);
	////////////////////////////////////////////////////////////////////////
	// Synchronisers
	logic sclk_s1_q;
	logic sclk_s2_q;
	logic sclk_s3_q;
	logic sin_s1_q;
	logic sin_s2_q;
	logic strap_s1_q;
	logic strap_s2_q;
	logic sclk_rise;
	logic sclk_fall;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			sclk_s1_q <= 1'b0;
			sclk_s2_q <= 1'b0;
			sclk_s3_q <= 1'b0;
			sin_s1_q <= 1'b0;
			sin_s2_q <= 1'b0;
			strap_s1_q <= 1'b0;
			strap_s2_q <= 1'b0;
		end
		else
		begin
			sclk_s1_q <= eeprom_clk;
			sclk_s2_q <= sclk_s1_q;
			sclk_s3_q <= sclk_s2_q;
			sin_s1_q <= eeprom_serial_in;
			sin_s2_q <= sin_s1_q;
			strap_s1_q <= serial_load_strap;
			strap_s2_q <= strap_s1_q;
		end
	end

	// Edges seen only after the second flop, so no metastable fan-out
	assign sclk_rise = sclk_s2_q & ~sclk_s3_q;
	assign sclk_fall = ~sclk_s2_q & sclk_s3_q;

	////////////////////////////////////////////////////////////////////////
	// Sequencer
	scl_pkg::scl_state_type state_q;
	logic [1:0] wait_q;
	logic [4:0] bit_q;
	logic [15:0] tx_q;
	logic [7:0] rx_q;
	logic [7:0] addr_q;
	logic [1:0] lane_q;
	logic [5:0] word_q;
	logic [31:0] group_q;
	logic byte_done;
	logic [7:0] rx_byte;
	logic [7:0] read_instr;

	assign read_instr = `SCL_READ_INSTR;
	assign rx_byte = {rx_q[6:0], sin_s2_q};
	assign byte_done = (state_q == scl_pkg::SCL_ST_SHIFT) && sclk_rise && (bit_q == `SCL_LAST_BIT);

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state_q <= scl_pkg::SCL_ST_STRAP;
			wait_q <= 2'h0;
			addr_q <= 8'h00;
		end
		else
		begin
			case (state_q)
				scl_pkg::SCL_ST_STRAP:
				begin
					// Strap is trusted only once it has crossed the synchroniser
					wait_q <= wait_q + 2'h1;
					if (wait_q == `SCL_STRAP_WAIT)
					begin
						if (strap_s2_q)
						begin
							addr_q <= `SCL_MARKER_ADDR;
							state_q <= scl_pkg::SCL_ST_SELECT;
						end
						else
						begin
							state_q <= scl_pkg::SCL_ST_DONE;
						end
					end
				end
				scl_pkg::SCL_ST_SELECT:
				begin
					// Select only after a rising edge, so a full bit time precedes the next one
					if (sclk_rise)
					begin
						state_q <= scl_pkg::SCL_ST_SHIFT;
					end
				end
				scl_pkg::SCL_ST_SHIFT:
				begin
					if (byte_done)
					begin
						if (addr_q == `SCL_MARKER_ADDR)
						begin
							if (rx_byte == `SCL_MARKER)
							begin
								addr_q <= `SCL_DATA_ADDR;
								state_q <= scl_pkg::SCL_ST_DESELECT;
							end
							else
							begin
								state_q <= scl_pkg::SCL_ST_DONE;
							end
						end
						else if ((lane_q == `SCL_LAST_LANE && word_q == `SCL_LAST_WORD)
							|| addr_q == `SCL_LAST_ADDR)
						begin
							state_q <= scl_pkg::SCL_ST_DONE;
						end
						else
						begin
							addr_q <= addr_q + 8'h01;
							state_q <= scl_pkg::SCL_ST_DESELECT;
						end
					end
				end
				scl_pkg::SCL_ST_DESELECT:
				begin
					// Chip select stays high for at least one link period
					if (sclk_rise)
					begin
						state_q <= scl_pkg::SCL_ST_SELECT;
					end
				end
				scl_pkg::SCL_ST_DONE:
				begin
					state_q <= scl_pkg::SCL_ST_DONE;
				end
				default:
				begin
					state_q <= scl_pkg::SCL_ST_DONE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Serial shifter
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			eeprom_chip_select_n <= 1'b1;
			eeprom_serial_out <= 1'b0;
			tx_q <= 16'h0000;
			rx_q <= 8'h00;
			bit_q <= 5'h00;
		end
		else if (state_q == scl_pkg::SCL_ST_SELECT)
		begin
			if (sclk_rise)
			begin
				eeprom_chip_select_n <= 1'b0;
				eeprom_serial_out <= read_instr[7];
				tx_q <= {`SCL_READ_INSTR, addr_q};
				bit_q <= 5'h00;
			end
		end
		else if (state_q == scl_pkg::SCL_ST_SHIFT)
		begin
			if (sclk_rise)
			begin
				bit_q <= bit_q + 5'h01;
				if (bit_q >= `SCL_CMD_BITS)
				begin
					rx_q <= rx_byte;
				end
				if (bit_q == `SCL_LAST_BIT)
				begin
					eeprom_chip_select_n <= 1'b1;
				end
			end
			else if (sclk_fall && bit_q != `SCL_FIRST_BIT)
			begin
				// Output moves on the falling edge, memory samples on the rising one
				// First bit already stands from select; shifting before it is sampled loses it
				tx_q <= {tx_q[14:0], 1'b0};
				eeprom_serial_out <= (bit_q < `SCL_CMD_BITS) ? tx_q[14] : 1'b0;
			end
		end
		else
		begin
			eeprom_chip_select_n <= 1'b1;
			eeprom_serial_out <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Word assembly and configuration writes
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			lane_q <= 2'h0;
			word_q <= 6'h00;
			group_q <= 32'h00000000;
			cfg_wr_en <= 1'b0;
			cfg_wr_addr <= 8'h00;
			cfg_wr_data <= 32'h00000000;
		end
		else
		begin
			cfg_wr_en <= 1'b0;
			if (byte_done && addr_q != `SCL_MARKER_ADDR)
			begin
				group_q <= {rx_byte, group_q[31:8]};
				lane_q <= lane_q + 2'h1;
				if (lane_q == `SCL_LAST_LANE)
				begin
					cfg_wr_en <= 1'b1;
					cfg_wr_data <= {rx_byte, group_q[31:8]};
					cfg_wr_addr <= {word_q, 2'b00};
					word_q <= word_q + 6'h01;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Target gate
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			loading <= 1'b1;
			acc_retry <= 1'b0;
			acc_accept <= 1'b0;
			acc_reject <= 1'b0;
			sys_int <= 1'b0;
		end
		else
		begin
			loading <= (state_q != scl_pkg::SCL_ST_DONE);
			acc_retry <= acc_valid && loading;
			acc_accept <= acc_valid && !loading && acc_single_mem
				&& (acc_byte_en == `SCL_ALL_LANES);
			acc_reject <= acc_valid && !loading && !acc_single_mem;
			sys_int <= acc_valid && !loading && (acc_byte_en != `SCL_ALL_LANES);
		end
	end
endmodule // scl_loader

// >>> test/scl_loader_sva.sv
// Assertions on the loader ports
`timescale 1ns/1ps
module scl_loader_sva (
	input wire logic clk,
	input wire logic reset,
	input wire logic loading,
	input wire logic acc_valid,
	input wire logic [3:0] acc_byte_en,
	input wire logic acc_single_mem,
	input wire logic acc_retry,
	input wire logic acc_accept,
	input wire logic acc_reject,
	input wire logic sys_int,
	input wire logic cfg_wr_en,
	input wire logic [7:0] cfg_wr_addr,
	input wire logic eeprom_chip_select_n
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	retry_while_loading_a: assert property (acc_valid && loading |=> acc_retry && !acc_accept)
		else $error("access not retried while loading");
	accept_full_a: assert property (acc_valid && !loading && acc_byte_en == 4'hf && acc_single_mem
		|=> acc_accept && !acc_retry)
		else $error("full access not accepted");
	lane_int_a: assert property (acc_valid && !loading && acc_byte_en != 4'hf |=> sys_int)
		else $error("partial lanes without interrupt");
	reject_cmd_a: assert property (acc_valid && !loading && !acc_single_mem |=> acc_reject)
		else $error("unsupported access not rejected");
	word_align_a: assert property (cfg_wr_en |-> cfg_wr_addr[1:0] == 2'h0)
		else $error("unaligned configuration write");
	write_pulse_a: assert property (cfg_wr_en |=> !cfg_wr_en)
		else $error("configuration write not a pulse");
	select_hold_a: assert property ($fell(eeprom_chip_select_n) |=> !eeprom_chip_select_n [*8])
		else $error("chip select too short");
	idle_deselect_a: assert property (!loading && !$past(loading) |-> eeprom_chip_select_n)
		else $error("memory selected after loading");
endmodule // scl_loader_sva
bind scl_loader scl_loader_sva u_sva (.clk, .reset, .loading, .acc_valid, .acc_byte_en,
	.acc_single_mem, .acc_retry, .acc_accept, .acc_reject, .sys_int, .cfg_wr_en, .cfg_wr_addr,
	.eeprom_chip_select_n);

// >>> test/scl_eeprom_model.sv
// Serial memory model with byte addressing
`timescale 1ns/1ps
module scl_eeprom_model (
	input wire logic reset,
	input wire logic eeprom_clk,
	input wire logic eeprom_chip_select_n,
	input wire logic eeprom_serial_out,
	input wire logic [7:0] first_byte,
	output logic eeprom_serial_in,
	output logic mem_err
);
	logic [15:0] sr;
	logic [7:0] d;
	logic [7:0] exp_a;
	int cnt;
	initial
	begin
		exp_a = 0;
		mem_err = 0;
		eeprom_serial_in = 0;
	end
	always @(posedge reset)
	begin
		exp_a = 0;
		mem_err = 0;
	end
	always @(negedge eeprom_chip_select_n) cnt = 0;
	always @(posedge eeprom_clk)
		if (!eeprom_chip_select_n)
		begin
			sr = {sr[14:0], eeprom_serial_out};
			cnt++;
			if (cnt == 16)
			begin
				mem_err |= sr !== {8'h03, exp_a};
				d = exp_a == 8'h00 ? first_byte : exp_a ^ 8'h5a;
				exp_a++;
			end
		end
	always @(negedge eeprom_clk)
		if (!eeprom_chip_select_n && cnt >= 16 && cnt < 24) eeprom_serial_in = d[23 - cnt];
	// Released line must not look like held data
	always @(posedge eeprom_chip_select_n) eeprom_serial_in = ~eeprom_serial_in;
endmodule // scl_eeprom_model

// >>> test/scl_loader_tb.sv
// Testbench of the serial configuration loader
`timescale 1ns/1ps
`define CHK(n, e, a) \
	total_checks++; \
	if ((e) !== (a)) \
	begin \
		n_mismatch++; \
		$display("mismatch %s exp %h got %h", n, e, a); \
	end
module scl_loader_tb;
	logic clk = 0, reset = 1, serial_load_strap = 1, eeprom_clk = 0, acc_valid = 0;
	logic acc_single_mem = 1, eeprom_serial_in, eeprom_chip_select_n, eeprom_serial_out;
	logic cfg_wr_en, loading, acc_retry, acc_accept, acc_reject, sys_int, mem_err;
	logic [3:0] acc_byte_en = 4'hf;
	logic [7:0] first_byte = 8'haa, cfg_wr_addr;
	logic [31:0] cfg_wr_data;
	int n_wr, n_mismatch, total_checks;
	scl_loader dut (.clk, .reset, .serial_load_strap, .eeprom_clk, .eeprom_serial_in,
		.eeprom_chip_select_n, .eeprom_serial_out, .cfg_wr_en, .cfg_wr_addr, .cfg_wr_data,
		.loading, .acc_valid, .acc_byte_en, .acc_single_mem, .acc_retry, .acc_accept,
		.acc_reject, .sys_int);
	scl_eeprom_model mem (.reset, .eeprom_clk, .eeprom_chip_select_n, .eeprom_serial_out,
		.first_byte, .eeprom_serial_in, .mem_err);
	initial forever #20 clk = ~clk;
	initial
	begin
		#7;
		forever #160 eeprom_clk = ~eeprom_clk;
	end
	function automatic logic [7:0] mb(input int a);
		return 8'(a) ^ 8'h5a;
	endfunction
	// Sampled mid-cycle, clear of the edge that launches the pulse
	always @(negedge clk)
		if (cfg_wr_en === 1'b1)
		begin
			`CHK("wr addr", 8'(n_wr * 4), cfg_wr_addr)
			`CHK("wr data", {mb(4*n_wr+4), mb(4*n_wr+3), mb(4*n_wr+2), mb(4*n_wr+1)}, cfg_wr_data)
			n_wr++;
		end
	////////////////////////////////////////////////////////////////
	task finish_test;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task do_reset(input logic s, input logic [7:0] fb);
		@(negedge clk);
		reset = 1;
		serial_load_strap = s;
		first_byte = fb;
		n_wr = 0;
		repeat (10) @(negedge clk);
		reset = 0;
	endtask
	// Called at a falling edge, so consecutive calls are back to back
	task acc(input logic [3:0] be, input logic sm, input logic [3:0] exp);
		acc_valid = 1;
		acc_byte_en = be;
		acc_single_mem = sm;
		@(negedge clk);
		`CHK("response", exp, {acc_retry, acc_accept, acc_reject, sys_int})
	endtask
	task wait_idle(input int n);
		for (int i = 0; i < n && loading !== 1'b0; i++) @(negedge clk);
		if (loading !== 1'b0)
		begin
			n_mismatch++;
			finish_test;
		end
	endtask
	////////////////////////////////////////////////////////////////
	task t_load;
		do_reset(1, 8'haa);
		acc(4'hf, 1, 4'h8);
		acc(4'h3, 1, 4'h8);
		acc_valid = 0;
		wait_idle(20000);
		`CHK("words", 16, n_wr)
		`CHK("mem order", 1'b0, mem_err)
		acc(4'hf, 1, 4'h4);
		acc(4'h3, 1, 4'h1);
		acc(4'hf, 0, 4'h2);
		acc(4'h1, 0, 4'h3);
		acc_valid = 0;
		$display("load test done");
	endtask
	task t_bad;
		do_reset(1, 8'h55);
		wait_idle(2000);
		`CHK("words", 0, n_wr)
		`CHK("mem order", 1'b0, mem_err)
		acc(4'hf, 1, 4'h4);
		acc_valid = 0;
		$display("bad marker test done");
	endtask
	task t_strap;
		do_reset(0, 8'haa);
		wait_idle(12);
		`CHK("words", 0, n_wr)
		acc(4'hf, 1, 4'h4);
		acc_valid = 0;
		$display("strap test done");
	endtask
	initial
	begin
		t_load;
		t_bad;
		t_strap;
		finish_test;
	end
endmodule // scl_loader_tb
